// *** verilog/sbec_pkg.sv ***
// package: constants and types for the serial boost/equalizer configuration chain
package sbec_pkg;
   // ======================================================================
   // word layout
   localparam int WORD_BITS = 5;
   localparam int BOOST_BITS = 4;
   localparam int EQ_POS = 0;
   localparam int BOOST_MSB = 4;
   localparam int BOOST_LSB = 1;
   // ======================================================================
   // values after reset
   localparam logic [3:0] BOOST_RESET = 4'h0;
   localparam logic EQ_RESET = 1'b0;
   localparam logic [4:0] SHIFT_RESET = 5'h00;
   // ======================================================================
   // boost table: fifteen steps over 0..12 dB, in tenths of a dB
   localparam int BOOST_MAX_TENTH_DB = 120;
   localparam int BOOST_STEPS = 15;
   localparam int SYNC_STAGES = 2;
   typedef logic [4:0] sbec_word_t;
   typedef logic [7:0] sbec_tenth_db_t;
endpackage : sbec_pkg

// *** verilog/sbec_edge_if.sv ***
// interface: synchronised serial pins and edge events between the modules
`timescale 1ns/1ns
`default_nettype none
interface sbec_edge_if;
   logic clk_level;
   logic clk_rise;
   logic data_level;
   logic strobe_level;
   logic strobe_rise;
   modport source (output clk_level, clk_rise, data_level, strobe_level, strobe_rise);
   modport sink (input clk_level, clk_rise, data_level, strobe_level, strobe_rise);
endinterface : sbec_edge_if
`default_nettype wire

// *** verilog/sbec_pin_sync.sv ***
// module: two-flop synchronisers and edge detection for the serial pins
`timescale 1ns/1ns
`default_nettype none
module sbec_pin_sync (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk_pin,
   input wire logic sdata_pin,
   input wire logic strobe_pin,
   sbec_edge_if.source ev
);
   // ======================================================================
   // synchronisers; first stage is read only by the second
   logic [2:0] meta;
   logic [2:0] sync;
   logic [2:0] prev;
   logic [2:0] next_meta;
   logic [2:0] next_sync;
   logic [2:0] next_prev;
   always_comb begin
      next_meta = {strobe_pin, sdata_pin, sclk_pin};
      next_sync = meta;
      next_prev = sync;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= 3'h0;
         sync <= 3'h0;
         prev <= 3'h0;
      end else begin
         meta <= next_meta;
         sync <= next_sync;
         prev <= next_prev;
      end
   end
   always_comb begin
      ev.clk_level = sync[0];
      ev.data_level = sync[1];
      ev.strobe_level = sync[2];
      ev.clk_rise = sync[0] & ~prev[0];
      ev.strobe_rise = sync[2] & ~prev[2];
   end
endmodule : sbec_pin_sync
`default_nettype wire

// *** verilog/sbec_boost_decode.sv ***
// module: boost code to compensation level in tenths of a dB
`timescale 1ns/1ns
`default_nettype none
module sbec_boost_decode (
   input wire logic [3:0] code,
   output logic [7:0] tenth_db
);
   // ======================================================================
   // linear map: code 0 is 0 dB, code 15 is 12 dB
   function automatic logic [7:0] to_tenths(input logic [3:0] c);
      int t;
      t = (int'(c) * sbec_pkg::BOOST_MAX_TENTH_DB) / sbec_pkg::BOOST_STEPS;
      return t[7:0];
   endfunction : to_tenths
   always_comb begin
      tenth_db = to_tenths(code);
   end
endmodule : sbec_boost_decode
`default_nettype wire

// *** verilog/sbec_config_chain.sv ***
// top: serial configuration shift chain with strobe-latched boost and equalizer settings
// Overview of operation
// - shift five-bit register on each serial clock rise
// - four boost bits select sixteen levels
// - boost held at zero dB after start-up
// - fifth word bit is equalizer enable
// - enable low bypasses equalizer, high routes through
// - equalizer enable low after start-up
// - data out from register end, one cycle after clock out
// - first bit appears out on fifth clock
// - shifting accepted at either strobe level
// - strobe rise updates all devices together
// - strobe rise captures register into held settings
// - strobe low forces zero dB, equalizer off
`timescale 1ns/1ns
`default_nettype none
module sbec_config_chain (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic SERIAL_CONFIG_IN,
   input wire logic SERIAL_CONFIG_CLOCK_IN,
   input wire logic SETTINGS_LATCH_STROBE,
   input wire logic LINE_DATA_IN,
   output logic SERIAL_CONFIG_OUT,
   output logic SERIAL_CONFIG_CLOCK_OUT,
   output logic [3:0] OUTPUT_BOOST_LEVEL,
   output logic [7:0] OUTPUT_BOOST_TENTH_DB,
   output logic EQUALIZER_ENABLE_BIT,
   output logic LINE_TO_EQUALIZER,
   output logic LINE_BYPASS
);
   // ======================================================================
   // pin synchronisation
   sbec_edge_if ev ();
   sbec_pin_sync u_sync (
      .clk(CLK_SYS),
      .reset_n(RESET_N),
      .sclk_pin(SERIAL_CONFIG_CLOCK_IN),
      .sdata_pin(SERIAL_CONFIG_IN),
      .strobe_pin(SETTINGS_LATCH_STROBE),
      .ev(ev)
   );
   logic line_meta;
   logic line_sync;
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         line_meta <= 1'b0;
         line_sync <= 1'b0;
      end else begin
         line_meta <= LINE_DATA_IN;
         line_sync <= line_meta;
      end
   end
   // ======================================================================
   // shift register; shifting runs regardless of strobe, latches guard settings
   sbec_pkg::sbec_word_t shift;
   sbec_pkg::sbec_word_t next_shift;
   always_comb begin
      next_shift = shift;
      if (ev.clk_rise) begin
         next_shift = {shift[sbec_pkg::WORD_BITS-2:0], ev.data_level};
      end
   end
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         shift <= sbec_pkg::SHIFT_RESET;
      end else begin
         shift <= next_shift;
      end
   end
   // ======================================================================
   // held settings
   logic [3:0] boost;
   logic eq_en;
   logic [3:0] next_boost;
   logic next_eq_en;
   always_comb begin
      next_boost = boost;
      next_eq_en = eq_en;
      if (!ev.strobe_level) begin
         next_boost = sbec_pkg::BOOST_RESET;
         next_eq_en = sbec_pkg::EQ_RESET;
      end else if (ev.strobe_rise) begin
         next_boost = shift[sbec_pkg::BOOST_MSB:sbec_pkg::BOOST_LSB];
         next_eq_en = shift[sbec_pkg::EQ_POS];
      end
   end
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         boost <= sbec_pkg::BOOST_RESET;
         eq_en <= sbec_pkg::EQ_RESET;
      end else begin
         boost <= next_boost;
         eq_en <= next_eq_en;
      end
   end
   // ======================================================================
   // level decode; output registered so every port comes from a flop
   logic [7:0] tenth_db;
   sbec_boost_decode u_dec (
      .code(boost),
      .tenth_db(tenth_db)
   );
   // ======================================================================
   // output registers
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         SERIAL_CONFIG_OUT <= 1'b0;
         SERIAL_CONFIG_CLOCK_OUT <= 1'b0;
         OUTPUT_BOOST_LEVEL <= sbec_pkg::BOOST_RESET;
         OUTPUT_BOOST_TENTH_DB <= 8'h00;
         EQUALIZER_ENABLE_BIT <= sbec_pkg::EQ_RESET;
         LINE_TO_EQUALIZER <= 1'b0;
         LINE_BYPASS <= 1'b0;
      end else begin
         // data out trails clock out
         // one cycle late so the next device still samples the old bit on that rise
         SERIAL_CONFIG_OUT <= shift[sbec_pkg::WORD_BITS-1];
         SERIAL_CONFIG_CLOCK_OUT <= ev.clk_level;
         OUTPUT_BOOST_LEVEL <= boost;
         OUTPUT_BOOST_TENTH_DB <= tenth_db;
         EQUALIZER_ENABLE_BIT <= eq_en;
         LINE_TO_EQUALIZER <= eq_en & line_sync;
         LINE_BYPASS <= ~eq_en & line_sync;
      end
   end
endmodule : sbec_config_chain
`default_nettype wire

// *** verification/sbec_config_chain_assertions.sv ***
// checker: port properties of the configuration chain
`timescale 1ns/1ns
`default_nettype none
module sbec_chk (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic SERIAL_CONFIG_CLOCK_IN,
   input wire logic SETTINGS_LATCH_STROBE,
   input wire logic SERIAL_CONFIG_OUT,
   input wire logic SERIAL_CONFIG_CLOCK_OUT,
   input wire logic [3:0] OUTPUT_BOOST_LEVEL,
   input wire logic [7:0] OUTPUT_BOOST_TENTH_DB,
   input wire logic EQUALIZER_ENABLE_BIT,
   input wire logic LINE_TO_EQUALIZER,
   input wire logic LINE_BYPASS
);
   wire logic st = SETTINGS_LATCH_STROBE;
   wire logic eq = EQUALIZER_ENABLE_BIT;
   wire logic ci = SERIAL_CONFIG_CLOCK_IN;
   wire logic co = SERIAL_CONFIG_CLOCK_OUT;
   wire logic so = SERIAL_CONFIG_OUT;
   wire logic [3:0] bl = OUTPUT_BOOST_LEVEL;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   // margins cover the two-flop sync plus the settings register
   property p_clear; !st [*7] |-> bl == 4'h0 && !eq; endproperty
   property p_hold; st [*8] |-> $stable(bl) && $stable(eq); endproperty
   property p_cap; ($rose(eq) || bl != 4'h0 && $changed(bl)) |-> $past(st, 3); endproperty
   property p_tdb; OUTPUT_BOOST_TENTH_DB == {1'b0, bl, 3'h0}; endproperty
   property p_on; eq [*2] |-> !LINE_BYPASS; endproperty
   property p_off; !eq [*2] |-> !LINE_TO_EQUALIZER; endproperty
   property p_crise; $rose(ci) |-> ##[2:5] $rose(co); endproperty
   property p_cfall; $fell(ci) |-> ##[2:5] $fell(co); endproperty
   property p_sdo; $changed(so) |-> ##[0:1] co; endproperty
   a_clear: assert property (p_clear) else $error("settings not cleared");
   a_hold: assert property (p_hold) else $error("settings moved");
   a_cap: assert property (p_cap) else $error("capture without strobe");
   a_tdb: assert property (p_tdb) else $error("boost level map");
   a_on: assert property (p_on) else $error("bypass while enabled");
   a_off: assert property (p_off) else $error("equalizer while off");
   a_crise: assert property (p_crise) else $error("clock out rise");
   a_cfall: assert property (p_cfall) else $error("clock out fall");
   a_sdo: assert property (p_sdo) else $error("data out off clock");
   c_eq: cover property (st ##1 eq);
   c_max: cover property (bl == 4'hF);
   c_sdo: cover property ($rose(so));
endmodule : sbec_chk
bind sbec_config_chain sbec_chk u_sbec_chk (.*);
`default_nettype wire

// *** verification/sbec_ctrl_model.sv ***
// model: controller driving serial data, clock and strobe
`timescale 1ns/1ns
`default_nettype none
module sbec_ctrl_model (
   output logic sclk,
   output logic sdata,
   output logic strobe
);
   initial begin
      sclk = 1'b0;
      sdata = 1'b0;
      strobe = 1'b0;
   end
   // data set a half period before rise
   task automatic put(input logic b);
      sdata = b;
      #400 sclk = 1'b1;
      #400 sclk = 1'b0;
   endtask : put
   // msb first, five bits per device
   task automatic word(input logic [4:0] w);
      for (int i = 4; i >= 0; i--) begin
         put(w[i]);
      end
      // clock stands still, data no longer valid
      sdata = ~sdata;
   endtask : word
   // low to shift, high after frame
   task automatic set_strobe(input logic l);
      strobe = l;
   endtask : set_strobe
endmodule : sbec_ctrl_model
`default_nettype wire

// *** verification/testbench.sv ***
// testbench: configuration chain driven through the controller model
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sclk, sdata, strobe, sdo, co, eq, to_eq, byp;
   logic line_in = 1'b0;
   logic co_q = 1'b0;
   int co_rises = 0;
   logic [3:0] bl;
   logic [7:0] td;
   int bad_count = 0;
   int num_checks = 0;
   always #50 clk = ~clk;
   sbec_ctrl_model u_sbec_ctrl_model (.sclk(sclk), .sdata(sdata), .strobe(strobe));
   sbec_config_chain u_sbec_config_chain (.CLK_SYS(clk), .RESET_N(rst_n),
      .SERIAL_CONFIG_IN(sdata), .SERIAL_CONFIG_CLOCK_IN(sclk), .SETTINGS_LATCH_STROBE(strobe),
      .LINE_DATA_IN(line_in), .SERIAL_CONFIG_OUT(sdo), .SERIAL_CONFIG_CLOCK_OUT(co),
      .OUTPUT_BOOST_LEVEL(bl), .OUTPUT_BOOST_TENTH_DB(td), .EQUALIZER_ENABLE_BIT(eq),
      .LINE_TO_EQUALIZER(to_eq), .LINE_BYPASS(byp));
   // clock out rises counted away from the launching edge
   always @(negedge clk) begin
      if (co && !co_q) begin
         co_rises++;
      end
      co_q = co;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   task automatic strobe_to(input logic l);
      u_sbec_ctrl_model.set_strobe(l);
      wt(8);
   endtask : strobe_to
   task automatic held(input logic [4:0] w);
      chk({4'h0, bl}, {4'h0, w[4:1]});
      chk({7'h0, eq}, {7'h0, w[0]});
      chk(td, {1'b0, w[4:1], 3'h0});
      line_in = 1'b1;
      wt(4);
      chk({6'h0, to_eq, byp}, {6'h0, w[0], !w[0]});
      line_in = 1'b0;
      wt(4);
      chk({6'h0, to_eq, byp}, 8'h00);
   endtask : held
   task automatic t_codes;
      logic [4:0] w;
      for (int c = 0; c < 16; c++) begin
         w = {c[3:0], c[0] ^ c[1]};
         u_sbec_ctrl_model.word(w);
         wt(4);
         strobe_to(1'b1);
         held(w);
         strobe_to(1'b0);
         held(5'h00);
      end
   endtask : t_codes
   task automatic t_chain;
      logic [9:0] v;
      int n;
      v = {5'h16, 5'h1B};
      n = co_rises;
      u_sbec_ctrl_model.word(v[9:5]);
      wt(2);
      chk({7'h0, sdo}, {7'h0, v[9]});
      for (int i = 4; i >= 0; i--) begin
         u_sbec_ctrl_model.put(v[i]);
         wt(2);
         chk({7'h0, sdo}, {7'h0, v[4 + i]});
      end
      chk(8'(co_rises - n), 8'h0A);
      strobe_to(1'b1);
      held(v[4:0]);
      chk({7'h0, co}, 8'h00);
      u_sbec_ctrl_model.word(5'h04);
      wt(8);
      held(v[4:0]);
      chk({7'h0, sdo}, 8'h00);
      chk(8'(co_rises - n), 8'h0F);
      strobe_to(1'b0);
   endtask : t_chain
   // reset in mid-run, with settings held and strobe high
   task automatic t_reset;
      u_sbec_ctrl_model.word(5'h1F);
      wt(4);
      strobe_to(1'b1);
      held(5'h1F);
      rst_n = 1'b0;
      wt(5);
      chk({3'h0, bl, eq}, 8'h00);
      rst_n = 1'b1;
      wt(8);
      held(5'h00);
      strobe_to(1'b0);
   endtask : t_reset
   task automatic final_report;
      if (bad_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   initial begin
      wt(5);
      rst_n = 1'b1;
      wt(2);
      held(5'h00);
      t_codes();
      t_chain();
      t_reset();
      final_report();
   end
   // a stuck handshake must not hang the run
   initial begin
      #400000;
      bad_count++;
      final_report();
   end
endmodule : testbench
`default_nettype wire
